// ---- verilog/clsq_cfg.svh ----
// Constants of the colour light conversion sequencer: register map,
// field positions, reset values and timing figures.
// Assumes a 50 MHz pclk and byte addresses on an APB with 32-bit data.
`ifndef CLSQ_CFG_SVH
`define CLSQ_CFG_SVH

// Register byte addresses
`define CLSQ_ADDR_CTRL 8'h00
`define CLSQ_ADDR_INTEG 8'h04
`define CLSQ_ADDR_WAIT 8'h08
`define CLSQ_ADDR_LOW_THR 8'h0C
`define CLSQ_ADDR_HIGH_THR 8'h10
`define CLSQ_ADDR_PERSIST 8'h14
`define CLSQ_ADDR_GAIN 8'h18
`define CLSQ_ADDR_STATE 8'h1C
`define CLSQ_ADDR_CLEAR 8'h20
`define CLSQ_ADDR_RED 8'h24
`define CLSQ_ADDR_GREEN 8'h28
`define CLSQ_ADDR_BLUE 8'h2C
`define CLSQ_ADDR_IRQ_STATUS 8'h30
`define CLSQ_ADDR_IRQ_CLEAR 8'h34
`define CLSQ_ADDR_IRQ_ENABLE 8'h38

// Control register fields
`define CLSQ_CTRL_CONV 1
`define CLSQ_CTRL_WAIT 3
`define CLSQ_CTRL_THR 4
`define CLSQ_CTRL_SLEEP 6

// Interrupt status, clear and enable fields
`define CLSQ_IRQ_THR 0
`define CLSQ_IRQ_SAT 1
`define CLSQ_IRQ_DONE 2
`define CLSQ_IRQ_W 3

// Reset values
`define CLSQ_RST_CTRL 8'h00
`define CLSQ_RST_INTEG 8'hFF
`define CLSQ_RST_WAIT 8'hFF
`define CLSQ_RST_GAIN 2'h0
`define CLSQ_RST_PERSIST 4'h0

// Step decoding and count limits
`define CLSQ_STEPS_FULL 9'h100
`define CLSQ_LONG_STEPS 9'h040
`define CLSQ_COUNT_MAX 16'hFFFF
`define CLSQ_PER_STEP_SHIFT 10

// Gain codes and factors
`define CLSQ_GAIN_1X 2'h0
`define CLSQ_GAIN_4X 2'h1
`define CLSQ_GAIN_16X 2'h2
`define CLSQ_GAIN_64X 2'h3
`define CLSQ_FACTOR_1X 7'h01
`define CLSQ_FACTOR_4X 7'h04
`define CLSQ_FACTOR_16X 7'h10
`define CLSQ_FACTOR_64X 7'h40
`define CLSQ_FACTOR_POS 8

// Timing: one step is 2.78 ms, pclk period 20 ns
`define CLSQ_STEP_NS 2780000
`define CLSQ_CLK_NS 20

`endif

// ---- verilog/clsq_pkg.sv ----
// Types of the colour light conversion sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package clsq_pkg;

    typedef enum logic [1:0] {
        CLSQ_IDLE,
        CLSQ_INTEG,
        CLSQ_WAIT,
        CLSQ_SLEEP
    } clsq_state_t;

endpackage

// ---- verilog/clsq_sync.sv ----
// Two flip-flop synchroniser for a group of slow levels.
// Assumes each bit is stable for several pclk periods.
`timescale 1ns/10ps
`default_nettype none

module clsq_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/clsq_top.sv ----
// Conversion sequencer of a four-channel colour light sensor with APB registers.
// Assumes a 50 MHz pclk, an external modulator clock conv_clk and four
// converter bit streams, and an external pull-up on the interrupt line.
//
// Contract
// RULE1: One state machine sequences convert, wait, sleep
// RULE2: Integration made of whole 2.78 ms steps
// RULE3: Integration length from 1 to 256 steps
// RULE4: Steps are 256 minus integration setting
// RULE5: Counts capped per step or at 65535
// RULE6: Gain code selects 1x, 4x, 16x, 64x
// RULE7: All four channels integrate together
// RULE8: Optional wait phase in 2.78 ms steps
// RULE9: Threshold and saturation share interrupt pin
// RULE10: Each interrupt source enabled separately
// RULE11: Threshold interrupt needs consecutive out-of-range samples
// RULE12: Register accesses accepted at any rate
// RULE13: Converter enable starts and stops cycles
// RULE14: Wait enable switches the wait phase
// RULE15: Sleep at cycle end after an interrupt
// RULE16: Threshold interrupt needs its enable bit
// RULE17: Wait steps are 256 minus wait setting
// RULE18: Saturation interrupt when a channel hits maximum
`timescale 1ns/10ps
`default_nettype none
`include "clsq_cfg.svh"

module clsq_top
    import clsq_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `CLSQ_STEP_NS / `CLSQ_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_clk,
    input wire logic [3:0] conv_bit,
    output logic [1:0] analog_gain_select,
    output logic conv_active,
    output logic irq_o,
    output logic irq_oe
);

    // Steps from an 8-bit setting: 0xFF gives 1, 0x00 gives 256
    function automatic logic [8:0] decode_steps(input logic [7:0] setting);
        decode_steps = `CLSQ_STEPS_FULL - {1'b0, setting};
    endfunction

    // Count ceiling for a given number of steps
    function automatic logic [15:0] chan_max(input logic [8:0] steps);
        if (steps < `CLSQ_LONG_STEPS) begin
            chan_max = {steps[5:0], 10'h000};
        end else begin
            chan_max = `CLSQ_COUNT_MAX;
        end
    endfunction

    // Saturating increment
    function automatic logic [15:0] sat_inc(input logic [15:0] val, input logic [15:0] lim);
        if (val >= lim) begin
            sat_inc = lim;
        end else begin
            sat_inc = val + 16'h0001;
        end
    endfunction

    // Gain factor for a gain code
    function automatic logic [6:0] gain_factor(input logic [1:0] code);
        case (code)
            `CLSQ_GAIN_1X: gain_factor = `CLSQ_FACTOR_1X;
            `CLSQ_GAIN_4X: gain_factor = `CLSQ_FACTOR_4X;
            `CLSQ_GAIN_16X: gain_factor = `CLSQ_FACTOR_16X;
            default: gain_factor = `CLSQ_FACTOR_64X;
        endcase
    endfunction

    localparam logic [17:0] STEP_LAST = 18'(STEP_CYCLES - 1);

    // Registers
    logic [7:0] ctrl_q;
    logic [7:0] integ_set_q;
    logic [7:0] wait_set_q;
    logic [15:0] low_thr_q;
    logic [15:0] high_thr_q;
    logic [3:0] persist_q;
    logic [1:0] gain_q;
    logic [`CLSQ_IRQ_W-1:0] irq_stat_q;
    logic [`CLSQ_IRQ_W-1:0] irq_en_q;
    logic [15:0] data_q [4];
    logic [15:0] acc_q [4];

    // Sequencer state
    clsq_state_t state_q;
    clsq_state_t state_d;
    logic [17:0] tick_cnt_q;
    logic [8:0] steps_left_q;
    logic [8:0] steps_run_q;
    logic [3:0] persist_cnt_q;
    logic conv_clk_prev_q;

    // Synchronised link signals
    logic conv_clk_s;
    logic [3:0] conv_bit_s;

    clsq_sync #(
        .WIDTH(5)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({conv_clk, conv_bit}),
        .sync_out({conv_clk_s, conv_bit_s})
    );

    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable & pready;
    wire apb_wr = apb_access & pwrite;
    wire wr_ctrl = apb_wr & (paddr == `CLSQ_ADDR_CTRL);
    wire wr_integ = apb_wr & (paddr == `CLSQ_ADDR_INTEG);
    wire wr_wait = apb_wr & (paddr == `CLSQ_ADDR_WAIT);
    wire wr_low = apb_wr & (paddr == `CLSQ_ADDR_LOW_THR);
    wire wr_high = apb_wr & (paddr == `CLSQ_ADDR_HIGH_THR);
    wire wr_persist = apb_wr & (paddr == `CLSQ_ADDR_PERSIST);
    wire wr_gain = apb_wr & (paddr == `CLSQ_ADDR_GAIN);
    wire wr_irq_clr = apb_wr & (paddr == `CLSQ_ADDR_IRQ_CLEAR);
    wire wr_irq_en = apb_wr & (paddr == `CLSQ_ADDR_IRQ_ENABLE);

    // Control bits
    wire conv_on = ctrl_q[`CLSQ_CTRL_CONV];
    wire wait_on = ctrl_q[`CLSQ_CTRL_WAIT];
    wire thr_irq_on = ctrl_q[`CLSQ_CTRL_THR];
    wire sleep_on_irq = ctrl_q[`CLSQ_CTRL_SLEEP];

    // Step timing
    wire step_tick = (tick_cnt_q == STEP_LAST); // see RULE2
    wire last_step = step_tick & (steps_left_q == 9'h001);
    wire integ_done = (state_q == CLSQ_INTEG) & last_step;
    wire wait_done = (state_q == CLSQ_WAIT) & last_step;
    wire conv_edge = conv_clk_s & ~conv_clk_prev_q;
    wire [8:0] integ_steps = decode_steps(integ_set_q); // see RULE3 see RULE4
    wire [8:0] wait_steps = decode_steps(wait_set_q); // see RULE17
    wire [15:0] acc_lim = chan_max(steps_run_q); // see RULE5

    // Sample evaluation at the end of an integration
    wire [15:0] clear_res = (conv_edge & conv_bit_s[0]) ? sat_inc(acc_q[0], acc_lim)
        : acc_q[0];
    wire out_of_range = (clear_res < low_thr_q) | (clear_res > high_thr_q); // see RULE11
    wire [3:0] persist_next = out_of_range ? persist_cnt_q + {3'h0, ~&persist_cnt_q} : 4'h0;
    wire persist_met = out_of_range & (persist_cnt_q >= persist_q); // see RULE11
    wire thr_event = integ_done & thr_irq_on & persist_met; // see RULE16
    wire [3:0] at_max;
    wire sat_event = integ_done & (|at_max); // see RULE18
    wire [`CLSQ_IRQ_W-1:0] irq_set = {integ_done, sat_event, thr_event};
    wire irq_pending = |(irq_stat_q[`CLSQ_IRQ_SAT:`CLSQ_IRQ_THR]);
    wire go_sleep = sleep_on_irq & (thr_event | sat_event | irq_pending); // see RULE15

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_max
            assign at_max[ch] = (acc_q[ch] >= acc_lim) |
                ((sat_inc(acc_q[ch], acc_lim) >= acc_lim) & conv_edge & conv_bit_s[ch]);
        end
    endgenerate

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            CLSQ_IDLE: begin
                if (conv_on) begin
                    state_d = CLSQ_INTEG; // see RULE13
                end
            end
            CLSQ_INTEG: begin
                if (!conv_on) begin
                    state_d = CLSQ_IDLE; // see RULE13
                end else if (integ_done) begin
                    if (go_sleep) begin
                        state_d = CLSQ_SLEEP; // see RULE15
                    end else if (wait_on) begin
                        state_d = CLSQ_WAIT; // see RULE8 see RULE14
                    end else begin
                        state_d = CLSQ_INTEG;
                    end
                end
            end
            CLSQ_WAIT: begin
                if (!conv_on) begin
                    state_d = CLSQ_IDLE;
                end else if (!wait_on || wait_done) begin
                    state_d = CLSQ_INTEG; // see RULE14
                end
            end
            CLSQ_SLEEP: begin
                if (!irq_pending) begin
                    state_d = CLSQ_IDLE;
                end
            end
            default: begin
                state_d = CLSQ_IDLE;
            end
        endcase
    end

    wire start_integ = (state_d == CLSQ_INTEG) &
        ((state_q != CLSQ_INTEG) | integ_done);
    wire start_wait = (state_d == CLSQ_WAIT) & (state_q != CLSQ_WAIT);

    // Single sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CLSQ_IDLE;
        end else begin
            state_q <= state_d; // see RULE1
        end
    end

    // Step timer and step counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 18'h00000;
            steps_left_q <= 9'h000;
            steps_run_q <= 9'h000;
        end else if (start_integ) begin
            tick_cnt_q <= 18'h00000;
            steps_left_q <= integ_steps; // see RULE3
            steps_run_q <= integ_steps;
        end else if (start_wait) begin
            tick_cnt_q <= 18'h00000;
            steps_left_q <= wait_steps; // see RULE8
        end else if (state_q == CLSQ_INTEG || state_q == CLSQ_WAIT) begin
            tick_cnt_q <= step_tick ? 18'h00000 : tick_cnt_q + 18'h00001; // see RULE2
            if (step_tick) begin
                steps_left_q <= steps_left_q - 9'h001;
            end
        end else begin
            tick_cnt_q <= 18'h00000;
        end
    end

    // Shared integration of all four channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clk_prev_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= 16'h0000;
                data_q[i] <= 16'h0000;
            end
        end else begin
            conv_clk_prev_q <= conv_clk_s;
            for (int i = 0; i < 4; i++) begin
                if (integ_done) begin
                    data_q[i] <= (conv_edge & conv_bit_s[i]) ? sat_inc(acc_q[i], acc_lim)
                        : acc_q[i];
                end
                if (start_integ) begin
                    acc_q[i] <= 16'h0000; // see RULE7
                end else if (state_q == CLSQ_INTEG && conv_edge && conv_bit_s[i]) begin
                    acc_q[i] <= sat_inc(acc_q[i], acc_lim); // see RULE5 see RULE7
                end
            end
        end
    end

    // Persistence filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            persist_cnt_q <= 4'h0;
        end else if (integ_done) begin
            persist_cnt_q <= persist_next; // see RULE11
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CLSQ_RST_CTRL;
            integ_set_q <= `CLSQ_RST_INTEG;
            wait_set_q <= `CLSQ_RST_WAIT;
            low_thr_q <= 16'h0000;
            high_thr_q <= 16'h0000;
            persist_q <= `CLSQ_RST_PERSIST;
            gain_q <= `CLSQ_RST_GAIN;
            irq_en_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (wr_integ) begin
                integ_set_q <= pwdata[7:0];
            end
            if (wr_wait) begin
                wait_set_q <= pwdata[7:0];
            end
            if (wr_low) begin
                low_thr_q <= pwdata[15:0];
            end
            if (wr_high) begin
                high_thr_q <= pwdata[15:0];
            end
            if (wr_persist) begin
                persist_q <= pwdata[3:0];
            end
            if (wr_gain) begin
                gain_q <= pwdata[1:0]; // see RULE6
            end
            if (wr_irq_en) begin
                irq_en_q <= pwdata[`CLSQ_IRQ_W-1:0]; // see RULE10
            end
        end
    end

    // Sticky interrupt status: a set in the same cycle beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~({`CLSQ_IRQ_W{wr_irq_clr}} &
                pwdata[`CLSQ_IRQ_W-1:0])) | irq_set; // see RULE9
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (paddr)
            `CLSQ_ADDR_CTRL: rd_mux = {24'h000000, ctrl_q};
            `CLSQ_ADDR_INTEG: rd_mux = {24'h000000, integ_set_q};
            `CLSQ_ADDR_WAIT: rd_mux = {24'h000000, wait_set_q};
            `CLSQ_ADDR_LOW_THR: rd_mux = {16'h0000, low_thr_q};
            `CLSQ_ADDR_HIGH_THR: rd_mux = {16'h0000, high_thr_q};
            `CLSQ_ADDR_PERSIST: rd_mux = {28'h0000000, persist_q};
            `CLSQ_ADDR_GAIN: rd_mux = {17'h00000, gain_factor(gain_q), 6'h00, gain_q}; // see RULE6
            `CLSQ_ADDR_STATE: rd_mux = {7'h00, steps_left_q, 14'h0000, state_q};
            `CLSQ_ADDR_CLEAR: rd_mux = {16'h0000, data_q[0]};
            `CLSQ_ADDR_RED: rd_mux = {16'h0000, data_q[1]};
            `CLSQ_ADDR_GREEN: rd_mux = {16'h0000, data_q[2]};
            `CLSQ_ADDR_BLUE: rd_mux = {16'h0000, data_q[3]};
            `CLSQ_ADDR_IRQ_STATUS: rd_mux = {29'h00000000, irq_stat_q};
            `CLSQ_ADDR_IRQ_CLEAR: rd_mux = 32'h00000000;
            `CLSQ_ADDR_IRQ_ENABLE: rd_mux = {29'h00000000, irq_en_q};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // APB answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup; // see RULE12
            pslverr <= apb_setup & ~rd_ok;
            if (apb_setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_gain_select <= `CLSQ_RST_GAIN;
            conv_active <= 1'b0;
            irq_o <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            analog_gain_select <= gain_q; // see RULE6
            conv_active <= (state_d == CLSQ_INTEG);
            irq_o <= 1'b0;
            irq_oe <= |(irq_stat_q & irq_en_q); // see RULE9 see RULE10
        end
    end

endmodule

`default_nettype wire

// ---- testbench/clsq_asserts.sv ----
// Port checker of the conversion sequencer, bound to its top.
// Assumes the APB, link and interrupt ports of clsq_top.
`timescale 1ns/10ps
`default_nettype none
`include "clsq_cfg.svh"

module clsq_asserts #(
    parameter int unsigned STEP_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_clk,
    input wire logic [3:0] conv_bit,
    input wire logic [1:0] analog_gain_select,
    input wire logic conv_active,
    input wire logic irq_o,
    input wire logic irq_oe
);
    logic [31:0] act_cnt_q;
    logic [1:0] off_cnt_q;
    logic on_q;
    logic wait_q;
    logic [1:0] gain_q;
    wire acc_wr = psel && penable && pready && pwrite;
    wire gain_wr = acc_wr && paddr == `CLSQ_ADDR_GAIN;
    wire ctrl_wr = acc_wr && paddr == `CLSQ_ADDR_CTRL;
    wire mask_wr = acc_wr && paddr == `CLSQ_ADDR_IRQ_ENABLE && pwdata[3:0] == 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_q <= 32'h0;
            off_cnt_q <= 2'h0;
            on_q <= 1'b0;
            wait_q <= 1'b0;
            gain_q <= 2'h0;
        end else begin
            act_cnt_q <= (conv_active && !ctrl_wr) ? act_cnt_q + 32'h1 : 32'h0;
            wait_q <= ctrl_wr ? pwdata[`CLSQ_CTRL_WAIT] : wait_q;
            off_cnt_q <= on_q ? 2'h0 : (off_cnt_q == 2'h3 ? 2'h3 : off_cnt_q + 2'h1);
            on_q <= ctrl_wr ? pwdata[`CLSQ_CTRL_CONV] : on_q;
            gain_q <= gain_wr ? pwdata[1:0] : gain_q;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable && !$past(penable))
        else $error("pready outside first access cycle");
    a_err_unmapped: assert property (psel && !penable && paddr > 8'h38 |=> pslverr)
        else $error("no pslverr on unmapped address");
    a_err_mapped: assert property (psel && !penable && paddr <= 8'h38 &&
        paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("pslverr on mapped address");
    a_gain_follows_write: assert property (gain_wr |->
        ##[1:2] analog_gain_select == gain_q)
        else $error("gain output not updated");
    a_gain_only_written: assert property (!$stable(analog_gain_select) |->
        $past(gain_wr) || $past(gain_wr, 2))
        else $error("gain output changed without write");
    a_irq_low_level: assert property (irq_o == 1'b0)
        else $error("interrupt line driven high");
    a_irq_masked_off: assert property (mask_wr |=> ##1 !irq_oe)
        else $error("interrupt drives with all enables off");
    a_active_max_len: assert property (conv_active && wait_q |->
        act_cnt_q < 256 * STEP_CYCLES)
        else $error("integration longer than 256 steps");
    a_off_stops_conv: assert property (off_cnt_q == 2'h3 |-> !conv_active)
        else $error("converting with converter off");

    c_conv_end: cover property ($fell(conv_active));
    c_irq_drive: cover property ($rose(irq_oe));
    c_bus_err: cover property (pslverr);
endmodule

bind clsq_top clsq_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_clk(conv_clk), .conv_bit(conv_bit), .analog_gain_select(analog_gain_select),
    .conv_active(conv_active), .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

// ---- testbench/clsq_link_model.sv ----
// Converter front end: modulator clock and four channel bits.
// Assumes a frame is conv_active high; the clock stands still outside.
`timescale 1ns/10ps
`default_nettype none

module clsq_link_model (
    input wire logic frame,
    input wire logic [3:0] pattern,
    output logic conv_clk,
    output logic [3:0] conv_bit
);
    initial begin
        conv_clk = 1'b0;
        #7;
        forever begin
            #80;
            conv_clk = frame ? ~conv_clk : 1'b0;
        end
    end
    // Channels change together; released bits show the inverse
    assign conv_bit = frame ? pattern : ~pattern;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the conversion sequencer over APB.
// Assumes the link model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
`include "clsq_cfg.svh"

module tb_top;
    localparam int SC = 8400;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pattern = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_clk;
    logic [3:0] conv_bit;
    logic [1:0] analog_gain_select;
    logic conv_active;
    logic irq_o;
    logic irq_oe;
    logic [31:0] r;
    logic e;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    int hi;
    int lo;

    clsq_top #(.STEP_CYCLES(SC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_clk(conv_clk), .conv_bit(conv_bit),
        .analog_gain_select(analog_gain_select), .conv_active(conv_active), .irq_o(irq_o),
        .irq_oe(irq_oe));
    clsq_link_model u_link (.frame(conv_active), .pattern(pattern), .conv_clk(conv_clk),
        .conv_bit(conv_bit));

    always #10 pclk = ~pclk;

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] near(input int v, input int x);
        return (v >= x - 2 && v <= x + 2) ? 32'h1 : 32'h0;
    endfunction

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_act(input logic v, output int c);
        c = 0;
        while (conv_active !== v && c < 40000) begin
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic t_regs();
        apb(1'b0, `CLSQ_ADDR_CTRL, 32'h0);
        check("ctrl reset", r, 32'h0);
        apb(1'b0, `CLSQ_ADDR_INTEG, 32'h0);
        check("integ reset", r, 32'hFF);
        apb(1'b0, `CLSQ_ADDR_WAIT, 32'h0);
        check("wait reset", r, 32'hFF);
        apb(1'b0, `CLSQ_ADDR_IRQ_ENABLE, 32'h0);
        check("enable reset", r, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, `CLSQ_ADDR_WAIT, 32'h5A);
        apb(1'b0, `CLSQ_ADDR_WAIT, 32'h0);
        check("wait rw", r, 32'h5A);
    endtask

    task automatic t_gain();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `CLSQ_ADDR_GAIN, 32'(c));
            apb(1'b0, `CLSQ_ADDR_GAIN, 32'h0);
            check("gain factor", {25'h0, r[14:8]}, 32'h1 << (2 * c));
            check("gain pins", {30'h0, analog_gain_select}, 32'(c));
        end
    endtask

    // One integration, its wait, then stop; checks the stop and the wait length
    task automatic run_pair(input logic [7:0] integ, input logic [7:0] ctrl);
        apb(1'b1, `CLSQ_ADDR_INTEG, {24'h0, integ});
        apb(1'b1, `CLSQ_ADDR_WAIT, 32'hFF);
        apb(1'b1, `CLSQ_ADDR_CTRL, {24'h0, ctrl});
        wait_act(1'b1, n);
        wait_act(1'b0, hi);
        wait_act(1'b1, lo);
        apb(1'b1, `CLSQ_ADDR_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        check("stopped", {31'h0, conv_active}, 32'h0);
        check("wait len", near(lo, SC), 32'h1);
    endtask

    task automatic t_one_step();
        pattern <= 4'b0101;
        apb(1'b1, `CLSQ_ADDR_IRQ_ENABLE, 32'h2);
        run_pair(8'hFF, 8'h0A);
        check("len 1", near(hi, SC), 32'h1);
        apb(1'b0, `CLSQ_ADDR_CLEAR, 32'h0);
        check("clear cap", r, 32'd1024);
        apb(1'b0, `CLSQ_ADDR_GREEN, 32'h0);
        check("green", r, 32'd1024);
        apb(1'b0, `CLSQ_ADDR_RED, 32'h0);
        check("red", r, 32'h0);
        apb(1'b0, `CLSQ_ADDR_IRQ_STATUS, 32'h0);
        check("status", r & 32'h3, 32'h2);
        check("irq sat", {31'h0, irq_oe}, 32'h1);
        apb(1'b1, `CLSQ_ADDR_IRQ_CLEAR, 32'h7);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq_oe}, 32'h0);
    endtask

    task automatic t_two_step();
        pattern <= 4'b1010;
        run_pair(8'hFE, 8'h0A);
        check("len 2", near(hi, 2 * SC), 32'h1);
        apb(1'b0, `CLSQ_ADDR_BLUE, 32'h0);
        check("blue cap", r, 32'd2048);
        apb(1'b0, `CLSQ_ADDR_CLEAR, 32'h0);
        check("clear", r, 32'h0);
        apb(1'b1, `CLSQ_ADDR_IRQ_ENABLE, 32'h0);
        apb(1'b1, `CLSQ_ADDR_IRQ_CLEAR, 32'h7);
    endtask

    task automatic t_thresh();
        pattern <= 4'b0000;
        apb(1'b1, `CLSQ_ADDR_INTEG, 32'hFF);
        apb(1'b1, `CLSQ_ADDR_LOW_THR, 32'h64);
        apb(1'b1, `CLSQ_ADDR_PERSIST, 32'h1);
        apb(1'b1, `CLSQ_ADDR_IRQ_ENABLE, 32'h1);
        apb(1'b1, `CLSQ_ADDR_CTRL, 32'h5A);
        wait_act(1'b1, n);
        wait_act(1'b0, n);
        repeat (3) @(posedge pclk);
        check("persist wait", {31'h0, irq_oe}, 32'h0);
        wait_act(1'b1, n);
        wait_act(1'b0, n);
        repeat (3) @(posedge pclk);
        check("thr irq", {31'h0, irq_oe}, 32'h1);
        repeat (SC + 2000) @(posedge pclk);
        check("asleep", {31'h0, conv_active}, 32'h0);
        apb(1'b0, `CLSQ_ADDR_STATE, 32'h0);
        check("state", r & 32'h3, 32'h3);
        apb(1'b1, `CLSQ_ADDR_IRQ_CLEAR, 32'h7);
        apb(1'b1, `CLSQ_ADDR_CTRL, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_gain();
        t_one_step();
        t_two_step();
        t_thresh();
        print_verdict();
    end
endmodule
`default_nettype wire
